//--- acq_pkg.sv
// constants, register map and carrier types for the input acquisition block
// Overview of operation
// - all enabled channels captured at each sample clock
// - master clock comes from rate generator or strobe
// - master drives square wave on clock pin
// - target uses clock pin, ignores generator and strobe
// - clock master bit resets low
// - burst off means continuous sampling
// - each trigger acquires programmed number of channel sets
// - zero length burst runs until full or, as master, generator off
// - final value of a nonzero length burst carries last marker
// - busy flag during burst, triggers need ready
// - trigger master uses interval timer or software
// - software trigger always triggers
// - master emits low trigger pulse of 70-150 ns
// - target triggers on falling edge of trigger pin
// - pin pulses for any trigger; target edge triggers paths
// - store word holds data, lead, last, zero top
// - lead marker only on lowest enabled channel
// - store written only while store enable high
// - flush empties store and clears itself
// - sticky overrun and underrun, cleared by write/flush
// - store fill count is readable
// - threshold flag when count exceeds threshold
// - burst length low 24 bits, resets 0400h
// - disabled channels put nothing in store
package acq_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_BCR = 8'h00;
  localparam logic [7:0] OFS_STORE = 8'h18;
  localparam logic [7:0] OFS_RATE_B = 8'h20;
  localparam logic [7:0] OFS_IN_CFG = 8'h24;
  localparam logic [7:0] OFS_SIZE = 8'h28;
  localparam logic [7:0] OFS_THRESH = 8'h2c;
  // board control word bit positions
  localparam int BCR_BURST_EN = 0;
  localparam int BCR_TRIG_MASTER = 1;
  localparam int BCR_SW_CLK = 2;
  localparam int BCR_SW_TRIG = 3;
  localparam int BCR_STORE_EN = 4;
  localparam int BCR_FLUSH = 5;
  localparam int BCR_BUSY = 6;
  localparam int BCR_READY = 7;
  localparam int BCR_THR_FLAG = 8;
  localparam int BCR_OVF = 22;
  localparam int BCR_UNF = 23;
  localparam int BCR_CLK_MASTER = 24;
  localparam int BCR_RATE_A_EN = 26;
  localparam int BCR_RATE_B_EN = 27;
  // field layout of the other registers
  localparam int LEN_W = 24;
  localparam int CH_EN_LSB = 24;
  localparam int THR_W = 19;
  localparam int THR_FLAG = 19;
  // reset values
  localparam logic [23:0] RST_BURST_LEN = 24'h000400;
  localparam logic [3:0] RST_CH_EN = 4'hf;
  localparam logic [18:0] RST_THRESH = 19'h3fffe;
  localparam logic [23:0] RST_RATE_B = 24'h002760;
  // store geometry
  localparam int DEPTH = 262144;
  localparam int PTR_W = 18;
  localparam int CNT_W = 19;
  localparam logic [18:0] FULL_CNT = 19'h40000;
  // timing
  localparam int CLK_NS = 50;
  localparam int TRIG_PULSE_NS = 70;
  localparam logic [1:0] TRIG_PULSE_CYC = 2'((TRIG_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RATE_A_HALF = 8'h0a;

  typedef logic [3:0][15:0] adc_set_t;

  typedef struct packed {
    logic final_value_marker;
    logic lead;
    logic [15:0] data;
  } store_word_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'b01,
    B_RUN = 2'b10
  } burst_state_t;
endpackage

//--- sample_store.sv
// sample store: first-in first-out storage with fill count and flush
module sample_store (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input acq_pkg::store_word_t i_word,
  input wire logic i_pop,
  input wire logic i_flush,
  output acq_pkg::store_word_t o_head,
  output logic [18:0] o_count,
  output logic o_full,
  output logic o_empty
);
  typedef struct packed {
    logic [17:0] wr_ptr;
    logic [17:0] rd_ptr;
    logic [18:0] count;
  } store_st_t;

  store_st_t s;
  store_st_t next_s;
  acq_pkg::store_word_t mem [acq_pkg::DEPTH];
  logic do_push;
  logic do_pop;

  assign o_full = (s.count == acq_pkg::FULL_CNT);
  assign o_empty = (s.count == 19'h00000);
  assign o_count = s.count;
  assign o_head = mem[s.rd_ptr];

  // ==========================================================
  // pointer and count update
  always_comb begin
    next_s = s;
    do_push = i_push && !o_full && !i_flush;
    do_pop = i_pop && !o_empty && !i_flush;
    if (i_flush) begin
      next_s = '0;
    end else begin
      if (do_push) begin
        next_s.wr_ptr = 18'(s.wr_ptr + 18'h1);
      end
      if (do_pop) begin
        next_s.rd_ptr = 18'(s.rd_ptr + 18'h1);
      end
      if (do_push && !do_pop) begin
        next_s.count = 19'(s.count + 19'h1);
      end else if (do_pop && !do_push) begin
        next_s.count = 19'(s.count - 19'h1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[s.wr_ptr] <= i_word;
    end
  end
endmodule

//--- acq_control.sv
// input acquisition control: clocking, triggering, bursts and store access
module acq_control (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input acq_pkg::reg_req_t I_REG_REQ,
  output logic [31:0] O_REG_RDATA,
  input acq_pkg::adc_set_t I_ADC_DATA,
  output logic O_ADC_CONVERT,
  input wire logic I_CLK_PIN,
  output logic O_CLK_PIN,
  output logic O_CLK_PIN_OE,
  input wire logic I_TRIG_PIN,
  output logic O_TRIG_PIN,
  output logic O_TRIG_PIN_OE
);
  typedef struct packed {
    logic clk_master;
    logic trig_master;
    logic burst_en;
    logic store_en;
    logic rate_a_en;
    logic rate_b_en;
    logic ovf;
    logic unf;
    logic [23:0] burst_len;
    logic [3:0] ch_en;
    logic [18:0] thresh;
    logic [23:0] rate_b_div;
    logic [7:0] rate_a_cnt;
    logic clk_out;
    logic clk_oe;
    logic [23:0] rate_b_cnt;
    logic clk_pin_prev;
    logic trig_pin_prev;
    logic [1:0] trig_cnt;
    logic trig_out;
    logic trig_oe;
    acq_pkg::burst_state_t phase;
    logic [23:0] set_cnt;
    logic last_set;
    logic lead;
    logic [3:0] pend;
    acq_pkg::adc_set_t hold;
    logic convert;
    logic [31:0] rdata;
  } acq_st_t;

  acq_st_t s;
  acq_st_t next_s;

  acq_pkg::store_word_t push_word;
  acq_pkg::store_word_t head;
  logic [18:0] fill;
  logic full;
  logic empty;
  logic push;
  logic pop;
  logic flush;
  logic thr_flag;
  logic samp_evt;
  logic trig_evt;
  logic accept;
  logic rate_b_tick;
  logic src_on;
  logic lost;
  logic rd_store;
  logic wr_bcr;
  logic [1:0] ch;
  logic [3:0] rest;
  logic [31:0] wd;

  // lowest channel still waiting to be stored
  function automatic logic [1:0] low_ch(input logic [3:0] m);
    low_ch = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        low_ch = 2'(i);
      end
    end
  endfunction

  sample_store u_store (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_push(push),
    .i_word(push_word),
    .i_pop(pop),
    .i_flush(flush),
    .o_head(head),
    .o_count(fill),
    .o_full(full),
    .o_empty(empty)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    wd = I_REG_REQ.wdata;
    wr_bcr = I_REG_REQ.wr && (I_REG_REQ.addr == acq_pkg::OFS_BCR);
    rd_store = I_REG_REQ.rd && (I_REG_REQ.addr == acq_pkg::OFS_STORE);
    flush = wr_bcr && wd[acq_pkg::BCR_FLUSH];
    thr_flag = (fill > {s.thresh});
    pop = rd_store && !empty;

    // register writes
    if (wr_bcr) begin
      next_s.burst_en = wd[acq_pkg::BCR_BURST_EN];
      next_s.trig_master = wd[acq_pkg::BCR_TRIG_MASTER];
      next_s.store_en = wd[acq_pkg::BCR_STORE_EN];
      next_s.clk_master = wd[acq_pkg::BCR_CLK_MASTER];
      next_s.rate_a_en = wd[acq_pkg::BCR_RATE_A_EN];
      next_s.rate_b_en = wd[acq_pkg::BCR_RATE_B_EN];
    end
    if (I_REG_REQ.wr && (I_REG_REQ.addr == acq_pkg::OFS_IN_CFG)) begin
      next_s.burst_len = wd[acq_pkg::LEN_W-1:0];
      next_s.ch_en = wd[acq_pkg::CH_EN_LSB+3:acq_pkg::CH_EN_LSB];
    end
    if (I_REG_REQ.wr && (I_REG_REQ.addr == acq_pkg::OFS_THRESH)) begin
      next_s.thresh = wd[acq_pkg::THR_W-1:0];
    end
    if (I_REG_REQ.wr && (I_REG_REQ.addr == acq_pkg::OFS_RATE_B)) begin
      next_s.rate_b_div = wd[23:0];
    end

    // internal rate generator, a square wave at the converter clock
    samp_evt = 1'b0;
    if (s.clk_master && s.rate_a_en) begin
      if (s.rate_a_cnt == 8'(acq_pkg::RATE_A_HALF - 8'h1)) begin
        next_s.rate_a_cnt = 8'h00;
        next_s.clk_out = !s.clk_out;
        samp_evt = !s.clk_out;
      end else begin
        next_s.rate_a_cnt = 8'(s.rate_a_cnt + 8'h1);
      end
    end else begin
      next_s.rate_a_cnt = 8'h00;
      next_s.clk_out = 1'b0;
    end
    next_s.clk_oe = next_s.clk_master;
    next_s.clk_pin_prev = I_CLK_PIN;
    if (s.clk_master) begin
      samp_evt = samp_evt || (wr_bcr && wd[acq_pkg::BCR_SW_CLK]);
    end else begin
      samp_evt = I_CLK_PIN && !s.clk_pin_prev;
    end
    src_on = !s.clk_master || s.rate_a_en;

    // interval timer for burst triggers
    rate_b_tick = 1'b0;
    if (s.rate_b_en && (s.rate_b_div != 24'h000000)) begin
      if (s.rate_b_cnt >= 24'(s.rate_b_div - 24'h1)) begin
        next_s.rate_b_cnt = 24'h000000;
        rate_b_tick = 1'b1;
      end else begin
        next_s.rate_b_cnt = 24'(s.rate_b_cnt + 24'h1);
      end
    end else begin
      next_s.rate_b_cnt = 24'h000000;
    end

    // trigger sources and the shared trigger pin
    trig_evt = wr_bcr && wd[acq_pkg::BCR_SW_TRIG];
    next_s.trig_pin_prev = I_TRIG_PIN;
    if (s.trig_master) begin
      trig_evt = trig_evt || rate_b_tick;
    end else begin
      trig_evt = trig_evt || (!I_TRIG_PIN && s.trig_pin_prev);
    end
    if (s.trig_cnt != 2'h0) begin
      next_s.trig_cnt = 2'(s.trig_cnt - 2'h1);
    end
    if (s.trig_master && trig_evt && (s.trig_cnt == 2'h0)) begin
      next_s.trig_cnt = acq_pkg::TRIG_PULSE_CYC;
    end
    next_s.trig_out = !s.trig_master || (next_s.trig_cnt == 2'h0);
    next_s.trig_oe = s.trig_master;

    // burst sequencing
    accept = samp_evt && (s.pend == 4'h0) && (s.ch_en != 4'h0);
    unique case (s.phase)
      acq_pkg::B_IDLE: begin
        if (s.burst_en && trig_evt) begin
          next_s.phase = acq_pkg::B_RUN;
          next_s.set_cnt = 24'h000000;
        end
        if (s.burst_en) begin
          accept = 1'b0;
        end
      end
      acq_pkg::B_RUN: begin
        if (!s.burst_en) begin
          next_s.phase = acq_pkg::B_IDLE;
          accept = 1'b0;
        end else if (s.burst_len == 24'h000000) begin
          if (!src_on || full) begin
            next_s.phase = acq_pkg::B_IDLE;
            accept = 1'b0;
          end
        end else if (accept) begin
          next_s.set_cnt = 24'(s.set_cnt + 24'h1);
          if (24'(s.set_cnt + 24'h1) == s.burst_len) begin
            next_s.phase = acq_pkg::B_IDLE;
          end
        end
      end
    endcase

    // capture all channels together, then store them one by one
    next_s.convert = accept;
    if (accept) begin
      next_s.hold = I_ADC_DATA;
      next_s.pend = s.ch_en;
      next_s.lead = 1'b1;
      next_s.last_set = s.burst_en && (s.burst_len != 24'h000000)
                        && (24'(s.set_cnt + 24'h1) == s.burst_len);
    end
    ch = low_ch(s.pend);
    rest = s.pend & ~(4'h1 << ch);
    push_word.data = s.hold[ch];
    push_word.lead = s.lead;
    push_word.final_value_marker = s.last_set && (rest == 4'h0);
    push = (s.pend != 4'h0) && s.store_en && !flush;
    lost = push && full;
    if (s.pend != 4'h0) begin
      next_s.pend = rest;
      next_s.lead = 1'b0;
    end

    // sticky error flags: a new event beats a clear in the same cycle
    next_s.ovf = lost || (s.ovf && !flush
                 && !(wr_bcr && !wd[acq_pkg::BCR_OVF]));
    next_s.unf = (rd_store && empty) || (s.unf && !flush
                 && !(wr_bcr && !wd[acq_pkg::BCR_UNF]));

    // read data
    if (I_REG_REQ.rd) begin
      unique case (I_REG_REQ.addr)
        acq_pkg::OFS_BCR: begin
          next_s.rdata = 32'h00000000;
          next_s.rdata[acq_pkg::BCR_BURST_EN] = s.burst_en;
          next_s.rdata[acq_pkg::BCR_TRIG_MASTER] = s.trig_master;
          next_s.rdata[acq_pkg::BCR_STORE_EN] = s.store_en;
          next_s.rdata[acq_pkg::BCR_BUSY] = (s.phase == acq_pkg::B_RUN);
          next_s.rdata[acq_pkg::BCR_READY] = s.burst_en && (s.phase == acq_pkg::B_IDLE);
          next_s.rdata[acq_pkg::BCR_THR_FLAG] = thr_flag;
          next_s.rdata[acq_pkg::BCR_OVF] = s.ovf;
          next_s.rdata[acq_pkg::BCR_UNF] = s.unf;
          next_s.rdata[acq_pkg::BCR_CLK_MASTER] = s.clk_master;
          next_s.rdata[acq_pkg::BCR_RATE_A_EN] = s.rate_a_en;
          next_s.rdata[acq_pkg::BCR_RATE_B_EN] = s.rate_b_en;
        end
        acq_pkg::OFS_STORE: next_s.rdata = {14'h0000, head};
        acq_pkg::OFS_RATE_B: next_s.rdata = {8'h00, s.rate_b_div};
        acq_pkg::OFS_IN_CFG: next_s.rdata = {4'h0, s.ch_en, s.burst_len};
        acq_pkg::OFS_SIZE: next_s.rdata = {13'h0000, fill};
        acq_pkg::OFS_THRESH: next_s.rdata = {12'h000, thr_flag, s.thresh};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s <= '0;
      s.burst_len <= acq_pkg::RST_BURST_LEN;
      s.ch_en <= acq_pkg::RST_CH_EN;
      s.thresh <= acq_pkg::RST_THRESH;
      s.rate_b_div <= acq_pkg::RST_RATE_B;
      s.trig_out <= 1'b1;
      s.phase <= acq_pkg::B_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign O_REG_RDATA = s.rdata;
  assign O_ADC_CONVERT = s.convert;
  assign O_CLK_PIN = s.clk_out;
  assign O_CLK_PIN_OE = s.clk_oe;
  assign O_TRIG_PIN = s.trig_out;
  assign O_TRIG_PIN_OE = s.trig_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence s_pulse_low;
    !O_TRIG_PIN [*2];
  endsequence
  sequence s_pulse_end;
    O_TRIG_PIN;
  endsequence

  property p_trig_pulse;
    $fell(O_TRIG_PIN) |-> s_pulse_low ##1 s_pulse_end;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("trigger pulse width wrong");

  property p_clk_target;
    !s.clk_master |-> !O_CLK_PIN_OE ##1 !O_CLK_PIN;
  endproperty
  a_clk_target: assert property (p_clk_target)
    else $error("clock pin driven in target mode");

  property p_store_gate;
    !s.store_en |=> (fill <= $past(fill));
  endproperty
  a_store_gate: assert property (p_store_gate)
    else $error("store written while disabled");

  property p_ready;
    $rose(s.phase == acq_pkg::B_RUN) |-> $past(s.burst_en && trig_evt);
  endproperty
  a_ready: assert property (p_ready)
    else $error("burst started without trigger");

  property p_eob;
    push && push_word.final_value_marker |-> s.last_set && ($countones(s.pend) == 1);
  endproperty
  a_eob: assert property (p_eob)
    else $error("last marker on wrong value");

  property p_lead;
    accept ##1 s.store_en |-> push_word.lead && (ch == low_ch(s.ch_en));
  endproperty
  a_lead: assert property (p_lead)
    else $error("lead marker missing on first channel");

  property p_ovf;
    lost |=> s.ovf;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overrun not flagged");

  property p_unf;
    rd_store && empty |=> s.unf ##1 (s.unf || $past(flush || wr_bcr));
  endproperty
  a_unf: assert property (p_unf)
    else $error("underrun not held");

  property p_flush;
    flush |=> (fill == 19'h00000);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush left data in store");

  property p_thr;
    I_REG_REQ.rd && (I_REG_REQ.addr == acq_pkg::OFS_THRESH)
      |=> O_REG_RDATA[acq_pkg::THR_FLAG] == $past(fill > {s.thresh});
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold flag wrong");
endmodule

//--- acq_peer_model.sv
// far side of the acquisition block: converters and a synchronized peer board
module acq_peer_model (
  input wire logic i_clk,
  input wire logic i_clk_run,
  input wire logic i_trig_fire,
  output acq_pkg::adc_set_t o_adc,
  output logic o_clk_pin,
  output logic o_trig_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div;
  logic [1:0] low;
  // each converter shows its own channel number in the low bits
  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      o_adc[ch] = 16'hc0d0 + 16'(ch);
    end
  end
  initial begin
    div = 4'h0;
    low = 2'h0;
    o_clk_pin = 1'b0;
    o_trig_pin = 1'b1;
  end
  // peer clock stands low outside frames, 20 cycle period within them
  always @(negedge i_clk) begin
    if (i_clk_run) begin
      div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
      if (div == 4'h9) begin
        o_clk_pin <= ~o_clk_pin;
      end
    end else begin
      div <= 4'h0;
      o_clk_pin <= 1'b0;
    end
    if (i_trig_fire) begin
      low <= 2'h2;
    end else if (low != 2'h0) begin
      low <= low - 2'h1;
    end
    o_trig_pin <= ~(i_trig_fire | (low != 2'h0));
  end
endmodule

//--- tb_top.sv
// self-checking testbench for the input acquisition control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] a_bcr = acq_pkg::OFS_BCR;
  localparam logic [7:0] a_store = acq_pkg::OFS_STORE;
  localparam logic [7:0] a_cfg = acq_pkg::OFS_IN_CFG;
  localparam logic [7:0] a_size = acq_pkg::OFS_SIZE;
  localparam logic [7:0] a_thr = acq_pkg::OFS_THRESH;
  localparam logic [31:0] m_burst = 32'h1 << acq_pkg::BCR_BURST_EN;
  localparam logic [31:0] m_tm = 32'h1 << acq_pkg::BCR_TRIG_MASTER;
  localparam logic [31:0] m_swclk = 32'h1 << acq_pkg::BCR_SW_CLK;
  localparam logic [31:0] m_swtrig = 32'h1 << acq_pkg::BCR_SW_TRIG;
  localparam logic [31:0] m_st = 32'h1 << acq_pkg::BCR_STORE_EN;
  localparam logic [31:0] m_flush = 32'h1 << acq_pkg::BCR_FLUSH;
  localparam logic [31:0] m_busy = 32'h1 << acq_pkg::BCR_BUSY;
  localparam logic [31:0] m_ready = 32'h1 << acq_pkg::BCR_READY;
  localparam logic [31:0] m_thr = 32'h1 << acq_pkg::BCR_THR_FLAG;
  localparam logic [31:0] m_unf = 32'h1 << acq_pkg::BCR_UNF;
  localparam logic [31:0] m_cm = 32'h1 << acq_pkg::BCR_CLK_MASTER;
  localparam logic [31:0] m_ra = 32'h1 << acq_pkg::BCR_RATE_A_EN;
  localparam logic [31:0] m_rb = 32'h1 << acq_pkg::BCR_RATE_B_EN;
  localparam logic [31:0] m_base = m_cm | m_st | m_ra | m_burst | m_tm;
  logic clk;
  logic rst;
  acq_pkg::reg_req_t req;
  logic [31:0] rdata;
  acq_pkg::adc_set_t adc;
  logic convert, clk_out, clk_oe, trig_out, trig_oe;
  logic peer_clk, peer_trig, clk_run, fire, clk_lvl, trig_lvl;
  int mismatches;
  int compares;
  // shared pins resolve from whichever party drives them
  assign clk_lvl = clk_oe ? clk_out : peer_clk;
  assign trig_lvl = trig_oe ? trig_out : peer_trig;

  acq_control uut (.I_CLK(clk), .I_SYS_RST(rst), .I_REG_REQ(req), .O_REG_RDATA(rdata),
    .I_ADC_DATA(adc), .O_ADC_CONVERT(convert), .I_CLK_PIN(clk_lvl), .O_CLK_PIN(clk_out),
    .O_CLK_PIN_OE(clk_oe), .I_TRIG_PIN(trig_lvl), .O_TRIG_PIN(trig_out),
    .O_TRIG_PIN_OE(trig_oe));
  acq_peer_model peer (.i_clk(clk), .i_clk_run(clk_run), .i_trig_fire(fire), .o_adc(adc),
    .o_clk_pin(peer_clk), .o_trig_pin(peer_trig));

  // ==========================================================
  // bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, 32'h0};
    @(negedge clk);
    req = '0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  // poll the fill count under a bound, then compare it
  task automatic wait_count(input logic [18:0] exp);
    logic [31:0] d;
    int n;
    n = 0;
    rd(a_size, d);
    while (d[18:0] !== exp && n < 200) begin
      rd(a_size, d);
      n++;
    end
    check(d, {13'h0, exp});
  endtask
  // read sets back, enabled channels ascending
  task automatic drain(input int sets, input logic [3:0] en, input logic last);
    logic [31:0] d;
    int total;
    int k;
    logic first;
    total = sets * $countones(en);
    k = 0;
    for (int s = 0; s < sets; s++) begin
      first = 1'b1;
      for (int ch = 0; ch < 4; ch++) begin
        if (en[ch]) begin
          rd(a_store, d);
          k++;
          check(d, {14'h0, last && (k == total), first, 16'hc0d0 + 16'(ch)});
          first = 1'b0;
        end
      end
    end
  endtask
  task automatic summarize;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] d;
    int edges;
    int lows;
    logic prev;
    rst = 1'b1;
    req = '0;
    clk_run = 1'b0;
    fire = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    check({30'h0, clk_oe, trig_oe}, 32'h0);
    rdchk(a_bcr, 32'h0);
    rdchk(a_cfg, 32'h0f000400);
    rdchk(a_thr, 32'h0003fffe);
    rdchk(acq_pkg::OFS_RATE_B, 32'h00002760);
    rdchk(8'h3c, 32'h0);
    // software strobe as master, channels 0 and 2
    wr(a_cfg, 32'h05000000);
    wr(a_bcr, m_cm | m_swclk);
    repeat (8) @(negedge clk);
    rdchk(a_size, 32'h0);
    wr(a_bcr, m_cm | m_st | m_swclk);
    wait_count(19'h2);
    check({31'h0, clk_oe}, 32'h1);
    drain(1, 4'h5, 1'b0);
    rd(a_store, d);
    rdchk(a_bcr, m_cm | m_st | m_unf);
    wr(a_bcr, m_cm | m_st);
    rdchk(a_bcr, m_cm | m_st);
    // continuous rate-A sampling on channel 3
    wr(a_cfg, 32'h08000000);
    wr(a_bcr, m_cm | m_st | m_ra);
    edges = 0;
    lows = 0;
    prev = clk_out;
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      if (clk_out !== prev) begin
        edges++;
      end
      if (convert === 1'b1) begin
        lows++;
      end
      prev = clk_out;
    end
    check(32'(edges >= 19 && edges <= 21), 32'h1);
    check(32'(lows >= 9 && lows <= 11), 32'h1);
    wr(a_bcr, m_cm | m_st);
    rd(a_size, d);
    check(32'(d[18:0] > 19'h5), 32'h1);
    drain(int'(d[18:0]), 4'h8, 1'b0);
    // master burst of two sets, software trigger
    wr(a_cfg, 32'h0f000002);
    wr(a_bcr, m_base);
    repeat (60) @(negedge clk);
    rdchk(a_size, 32'h0);
    rdchk(a_bcr, m_base | m_ready);
    wr(a_bcr, m_base | m_swtrig);
    lows = 0;
    for (int i = 0; i < 6; i++) begin
      if (trig_out === 1'b0) begin
        lows++;
      end
      @(negedge clk);
    end
    check(32'(lows), 32'h2);
    rdchk(a_bcr, m_base | m_busy);
    wait_count(19'h8);
    wr(a_thr, 32'h7);
    rdchk(a_thr, 32'h00080007);
    rdchk(a_bcr, m_base | m_ready | m_thr);
    wr(a_thr, 32'h8);
    rdchk(a_thr, 32'h00000008);
    drain(2, 4'hf, 1'b1);
    // target mode: strobe and generator ignored, peer clock used
    wr(a_bcr, m_st | m_ra | m_swclk);
    repeat (60) @(negedge clk);
    rdchk(a_size, 32'h0);
    check({30'h0, clk_oe, trig_oe}, 32'h0);
    wr(a_bcr, m_st | m_burst);
    clk_run = 1'b1;
    wr(a_bcr, m_st | m_burst | m_swtrig);
    wait_count(19'h8);
    drain(2, 4'hf, 1'b1);
    @(negedge clk);
    fire <= 1'b1;
    @(negedge clk);
    fire <= 1'b0;
    wait_count(19'h8);
    wr(a_bcr, m_st | m_burst | m_flush);
    rdchk(a_size, 32'h0);
    rdchk(a_bcr, m_st | m_burst | m_ready);
    // interval timer starts an unending burst, generator off ends it
    wr(acq_pkg::OFS_RATE_B, 32'h00000040);
    wr(a_cfg, 32'h01000000);
    wr(a_bcr, m_base | m_rb);
    repeat (150) @(negedge clk);
    rdchk(a_bcr, m_base | m_rb | m_busy);
    rdchk(a_store, 32'h0001c0d0);
    wr(a_bcr, m_base & ~m_ra);
    rdchk(a_bcr, (m_base & ~m_ra) | m_ready);
    clk_run = 1'b0;
    summarize();
  end
endmodule
